// ---- hdl/ssp_spi_slave.v ----
`timescale 1ns/1ns
`include "ssp_regs.vh"

module ssp_spi_slave (
  input  wire                      sys_clk,
  input  wire                      reset_n,
  input  wire                      cs_n,
  input  wire                      sclk,
  input  wire                      shared_serial_data_pin_in,
  output wire                      shared_serial_data_pin_out,
  output wire                      shared_serial_data_pin_oe,
  output wire                      serial_out_pin,
  output wire                      serial_out_oe,
  output reg  [`SSP_ADDR_W-1:0]    reg_addr,
  output reg  [`SSP_DATA_W-1:0]    reg_wdata,
  output reg                       reg_wr,
  output reg                       reg_rd,
  input  wire [`SSP_DATA_W-1:0]    reg_rd_data,
  output reg                       three_wire_mode,
  output wire                      i2c_select
);

  // Synchroniser stages for the pins from the master
  reg                    cs_s1;        // First stage, chip select
  reg                    cs_s2;        // Second stage, chip select
  reg                    sclk_s1;      // First stage, serial clock
  reg                    sclk_s2;      // Second stage, serial clock
  reg                    sclk_d;       // Delayed copy for edge finding
  reg                    din_s1;       // First stage, data input
  reg                    din_s2;       // Second stage, data input

  // Frame state and datapath
  reg  [1:0]             phase;        // Current frame phase
  reg  [2:0]             bit_cnt;      // Bits received in this byte
  reg  [`SSP_DATA_W-1:0] shift_in;     // Receive shift register
  reg  [`SSP_DATA_W-1:0] shift_out;    // Transmit shift register
  reg                    out_bit;      // Bit now presented to the master
  reg                    is_read;      // Read bit of the command byte
  reg                    auto_inc;     // Auto-increment flag of the command byte
  reg                    first_done;   // First data byte of the frame finished
  reg                    read_drive;   // Data phase of a read is running
  reg                    fmt_hit_d;    // Format register write seen
  reg                    fmt_bit_d;    // Mode bit carried by that write

  // Edge and byte events on the system clock
  wire                   rise;         // Rising serial clock edge seen
  wire                   fall;         // Falling serial clock edge seen
  wire                   selected;     // Synchronised chip select active
  wire                   byte_end;     // Last bit of a byte sampled
  wire [`SSP_DATA_W-1:0] byte_val;     // Byte completed by this edge

  // Events come from the second stages only; CPOL=1, CPHA=1 timing
  assign rise     = sclk_s2 & ~sclk_d;
  assign fall     = ~sclk_s2 & sclk_d;
  assign selected = ~cs_s2;
  assign byte_end = selected & rise & (bit_cnt == `SSP_LAST_BIT);
  assign byte_val = {shift_in[`SSP_DATA_W-2:0], din_s2};

  // The other bus owns the pins while chip select is high
  assign i2c_select = cs_s2;

  // Four-wire: dedicated output line driven while the raw select is low
  assign serial_out_pin = out_bit;
  // Enable gated by the raw pin so release does not wait for the synchroniser
  assign serial_out_oe  = ~three_wire_mode & ~cs_n;

  // Three-wire: shared line driven only in a read's data phase
  assign shared_serial_data_pin_out = out_bit;
  assign shared_serial_data_pin_oe  = three_wire_mode & read_drive & ~cs_n;

  // Two-flop synchronisers for the asynchronous pins
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_d  <= 1'b1;
      din_s1  <= 1'b1;
      din_s2  <= 1'b1;
    end else begin
      cs_s1   <= cs_n;
      cs_s2   <= cs_s1;
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      din_s1  <= shared_serial_data_pin_in;
      din_s2  <= din_s1;
    end
  end

  // Frame sequencer: command byte, then data bytes until select rises
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase      <= `SSP_PH_IDLE;
      bit_cnt    <= `SSP_CNT_RST;
      shift_in   <= `SSP_BYTE_RST;
      is_read    <= 1'b0;
      auto_inc   <= 1'b0;
      first_done <= 1'b0;
      read_drive <= 1'b0;
      reg_addr   <= `SSP_ADDR_RST;
      reg_wdata  <= `SSP_BYTE_RST;
      reg_wr     <= 1'b0;
      reg_rd     <= 1'b0;
    end else begin
      // Strobes last one cycle
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (!selected) begin
        // Select high ends the frame; a partial byte is dropped
        phase      <= `SSP_PH_IDLE;
        bit_cnt    <= `SSP_CNT_RST;
        first_done <= 1'b0;
        read_drive <= 1'b0;
      end else begin
        case (phase)
          `SSP_PH_IDLE: begin
            // Select fell: start a new command byte
            phase   <= `SSP_PH_CMD;
            bit_cnt <= `SSP_CNT_RST;
          end
          `SSP_PH_CMD: begin
            if (rise) begin
              // Sample on the rising edge
              shift_in <= byte_val;
              bit_cnt  <= bit_cnt + 3'h1;
            end
            if (byte_end) begin
              // Decode read bit, increment flag and address
              is_read    <= byte_val[`SSP_CMD_RW_BIT];
              auto_inc   <= byte_val[`SSP_CMD_AUTO_BIT];
              reg_addr   <= byte_val[`SSP_ADDR_W-1:0];
              reg_rd     <= byte_val[`SSP_CMD_RW_BIT];
              read_drive <= byte_val[`SSP_CMD_RW_BIT];
              phase      <= `SSP_PH_DATA;
            end
          end
          `SSP_PH_DATA: begin
            if (rise) begin
              shift_in <= byte_val;
              bit_cnt  <= bit_cnt + 3'h1;
            end
            if (reg_wr && auto_inc) begin
              // Step on only after the write strobe has used the pointer
              reg_addr <= reg_addr + 6'h01;
            end
            if (byte_end) begin
              first_done <= 1'b1;
              // Only whole bytes are written; extra bytes need the flag
              if (!is_read && (auto_inc || !first_done)) begin
                reg_wr    <= 1'b1;
                reg_wdata <= byte_val;
              end
              if (is_read && auto_inc) begin
                // Reads step before fetching the next byte
                reg_addr <= reg_addr + 6'h01;
              end
              // Without the flag reads repeat the same register
              reg_rd <= is_read;
            end
          end
          default: begin
            phase <= `SSP_PH_IDLE;
          end
        endcase
      end
    end
  end

  // Format snoop: the write strobe still carries the pointer it writes to
  wire fmt_hit;
  assign fmt_hit = reg_wr & (reg_addr == `SSP_FMT_ADDR);

  // Hold the written bit one cycle before the mode takes it
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_hit_d <= 1'b0;
      fmt_bit_d <= `SSP_FMT_3WIRE_RST;
    end else begin
      fmt_hit_d <= fmt_hit;
      fmt_bit_d <= reg_wdata[`SSP_FMT_3WIRE_BIT];
    end
  end

  // Line mode follows the format register bit, taken from writes
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      three_wire_mode <= `SSP_FMT_3WIRE_RST;
    end else if (fmt_hit_d) begin
      three_wire_mode <= fmt_bit_d;
    end
  end

  // Transmit path: change output only on the falling edge; clear it while deselected
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_out <= `SSP_BYTE_RST;
      out_bit   <= 1'b0;
    end else begin
      if (!selected) begin
        out_bit <= 1'b0;
      end else if (reg_rd) begin
        // Read data is sampled while the strobe stands
        shift_out <= reg_rd_data;
      end else if (fall && read_drive) begin
        // Present the next bit, most significant first
        out_bit   <= shift_out[`SSP_DATA_W-1];
        shift_out <= {shift_out[`SSP_DATA_W-2:0], 1'b0};
      end
    end
  end

  // The port only answers; it owns no clock and no select output
  // and so never starts a transfer of its own.

endmodule

// ---- shared/ssp_regs.vh ----
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// Register address that holds the output format configuration
`define SSP_FMT_ADDR        6'h31
// Bit position of the 3-wire select inside the format register
`define SSP_FMT_3WIRE_BIT   6
// Reset value of the 3-wire select (4-wire after reset)
`define SSP_FMT_3WIRE_RST   1'b0

// Width of the register address carried in the command byte
`define SSP_ADDR_W          6
// Width of one data byte
`define SSP_DATA_W          8
// Position of the read/write bit in the command byte
`define SSP_CMD_RW_BIT      7
// Position of the auto-increment flag in the command byte
`define SSP_CMD_AUTO_BIT    6
// Index of the last bit of a byte within the bit counter
`define SSP_LAST_BIT        3'h7

// Reset values of the datapath
`define SSP_ADDR_RST        6'h00
`define SSP_BYTE_RST        8'h00
`define SSP_CNT_RST         3'h0

// Frame phases of the serial port
`define SSP_PH_IDLE         2'h0
`define SSP_PH_CMD          2'h1
`define SSP_PH_DATA         2'h2

// System clock period and serial timing figures in ns
`define SSP_SYS_CLK_NS      40
`define SSP_SCLK_MIN_NS     200
`define SSP_CS_GAP_MIN_NS   150
`define SSP_DIS_MAX_NS      10
// Least system cycles per serial clock period, rounded up
`define SSP_SCLK_MIN_CYC    ((`SSP_SCLK_MIN_NS + `SSP_SYS_CLK_NS - 1) / `SSP_SYS_CLK_NS)

`endif

// ---- tb/ssp_spi_master_model.sv ----
`timescale 1ns/1ns
// Host master model: mode 3 frames on its own serial clock
module ssp_spi_master_model (
  output reg  cs_n,
  output reg  sclk,
  output wire sdi,
  input  wire sdio_out,
  input  wire sdio_oe,
  input  wire so_pin,
  input  wire so_oe
);
  reg mdat; // Value the master puts out
  reg mdrv; // Master drives the data line
  // Released line shows a changing pattern, not the last bit
  assign sdi = sdio_oe ? sdio_out : (mdrv ? mdat : ~mdat);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    mdat = 1'b1;
    mdrv = 1'b1;
  end
  // Open a frame, with a setup gap before the first fall
  task automatic frame_start;
    cs_n = 1'b0;
    #120;
  endtask
  // Close a frame; data input held high while deselected
  task automatic frame_end;
    #200;
    cs_n = 1'b1;
    mdrv = 1'b1;
    mdat = 1'b1;
    #400;
  endtask
  // Clock n bits msb first: change on fall, sample on rise
  task automatic shift(input int n, input [7:0] tx, input bit listen, input bit w3, output [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk = 1'b0;
      mdrv = !listen;
      mdat = listen ? ~mdat : tx[i];
      #160;
      sclk = 1'b1;
      rx[i] = w3 ? sdi : (so_oe ? so_pin : 1'bx);
      #160;
    end
  endtask
endmodule

// ---- tb/ssp_spi_slave_assertions.sv ----
`timescale 1ns/1ns
`include "ssp_regs.vh"
// Port-level checks of the serial slave
module ssp_spi_slave_assertions (
  input wire       sys_clk, reset_n, cs_n, sclk, shared_serial_data_pin_in,
  input wire       shared_serial_data_pin_out, shared_serial_data_pin_oe, serial_out_pin, serial_out_oe,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rd_data,
  input wire       reg_wr, reg_rd, three_wire_mode, i2c_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  release_a: assert property (cs_n |-> !serial_out_oe && !shared_serial_data_pin_oe) else $error("pin driven off frame");
  four_wire_a: assert property (!cs_n && !three_wire_mode |-> serial_out_oe) else $error("no output in frame");
  three_wire_a: assert property (three_wire_mode |-> !serial_out_oe) else $error("output pin in 3-wire");
  no_shared_a: assert property (!three_wire_mode |-> !shared_serial_data_pin_oe) else $error("shared pin in 4-wire");
  wr_spacing_a: assert property (reg_wr |=> !reg_wr [*8]) else $error("write pulses too close");
  rd_spacing_a: assert property (reg_rd |=> !reg_rd [*8]) else $error("read pulses too close");
  slave_only_a: assert property (i2c_select && $past(i2c_select) |-> !reg_wr && !reg_rd) else $error("access off frame");
  bus_sel_a: assert property (cs_n [*4] |-> i2c_select) else $error("other bus not selected");
  bus_desel_a: assert property (!cs_n [*4] |-> !i2c_select) else $error("other bus selected");
  mode_take_a: assert property (reg_wr && reg_addr == `SSP_FMT_ADDR |-> ##3
    three_wire_mode == $past(reg_wdata[`SSP_FMT_3WIRE_BIT], 3)) else $error("mode bit not taken");
endmodule
bind ssp_spi_slave ssp_spi_slave_assertions ssp_spi_slave_assertions_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .cs_n(cs_n), .sclk(sclk), .shared_serial_data_pin_in(shared_serial_data_pin_in),
  .shared_serial_data_pin_out(shared_serial_data_pin_out), .shared_serial_data_pin_oe(shared_serial_data_pin_oe),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rd_data(reg_rd_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .three_wire_mode(three_wire_mode),
  .i2c_select(i2c_select));

// ---- tb/ssp_spi_slave_tb_top.sv ----
`timescale 1ns/1ns
`include "ssp_regs.vh"
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module ssp_spi_slave_tb_top;
  logic       sys_clk, reset_n, cs_n, sclk, sdi, sdio_out, sdio_oe, so_pin, so_oe;
  logic       reg_wr, reg_rd, three_wire_mode, i2c_select;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rd_data;
  logic [7:0] mem [0:63]; // Register space behind the port
  logic [23:0] rx;        // Bytes returned by a frame
  logic [7:0] b;          // Scratch byte
  int         mismatches, comparisons;
  assign reg_rd_data = mem[reg_addr];
  // Register space takes write pulses
  always @(posedge sys_clk) begin
    if (reg_wr) mem[reg_addr] <= reg_wdata;
  end
  ssp_spi_slave ssp_spi_slave_i (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
    .shared_serial_data_pin_in(sdi), .shared_serial_data_pin_out(sdio_out), .shared_serial_data_pin_oe(sdio_oe),
    .serial_out_pin(so_pin), .serial_out_oe(so_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .three_wire_mode(three_wire_mode), .i2c_select(i2c_select));
  ssp_spi_master_model ssp_spi_master_model_i (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .so_pin(so_pin), .so_oe(so_oe));
  // One whole frame: command byte then n data bytes
  task automatic frame(input [7:0] cmd, input int n, input [23:0] tx, input bit w3);
    ssp_spi_master_model_i.frame_start();
    ssp_spi_master_model_i.shift(8, cmd, 1'b0, w3, b);
    for (int k = 0; k < n; k++) begin
      ssp_spi_master_model_i.shift(8, tx[23-8*k -: 8], cmd[7], w3, b);
      rx[23-8*k -: 8] = b;
    end
    ssp_spi_master_model_i.frame_end();
  endtask
  // Plain write: only the first data byte lands
  task automatic sc_write_single;
    frame(8'h05, 2, 24'h123400, 1'b0);
    `CHK("reg 05", 8'h12, mem[5])
    `CHK("reg 06", 8'h5c, mem[6])
  endtask
  // Burst write across the address wrap
  task automatic sc_burst_write;
    frame(8'h7f, 3, 24'ha1b2c3, 1'b0);
    `CHK("burst wrap", 24'ha1b2c3, {mem[63], mem[0], mem[1]})
  endtask
  // Burst and repeated reads on the 4-wire output
  task automatic sc_reads;
    frame(8'hd0, 3, 24'h0, 1'b0);
    `CHK("burst read", 24'h4a4b48, rx)
    frame(8'ha0, 2, 24'h0, 1'b0);
    `CHK("plain read", 16'h7a7a, rx[23:8])
  endtask
  // Frame cut after half a data byte writes nothing
  task automatic sc_abort;
    ssp_spi_master_model_i.frame_start();
    ssp_spi_master_model_i.shift(8, 8'h08, 1'b0, 1'b0, b);
    ssp_spi_master_model_i.shift(4, 8'hff, 1'b0, 1'b0, b);
    ssp_spi_master_model_i.frame_end();
    `CHK("aborted reg", 8'h52, mem[8])
  endtask
  // Switch to 3-wire, read on the shared pin, switch back
  task automatic sc_three_wire;
    frame(8'h31, 1, 24'h400000, 1'b0);
    `CHK("3-wire mode", 1'b1, three_wire_mode)
    frame(8'hd0, 2, 24'h0, 1'b1);
    `CHK("3-wire read", 16'h4a4b, rx[23:8])
    frame(8'h31, 1, 24'h000000, 1'b1);
    `CHK("4-wire mode", 1'b0, three_wire_mode)
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK("bus select", 1'b1, i2c_select)
    `CHK("reset mode", 1'b0, three_wire_mode)
    sc_write_single();
    sc_burst_write();
    sc_reads();
    sc_abort();
    sc_three_wire();
    give_verdict();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
